// ==== verilog/cpf_pkg.sv ====
package cpf_pkg;

  // ----------------------------------------------------------------
  // Sizes, counts and reset values
  // ----------------------------------------------------------------
  localparam int GPR_COUNT = 8;
  localparam logic [2:0] SP_INDEX = 3'h7;
  localparam logic [31:0] SP_STEP = 32'h00000004;
  localparam logic [7:0] FLAGS_RESET = 8'h80;
  localparam logic [23:0] PC_RESET = 24'h000000;
  localparam logic [23:0] AMASK_NORMAL = 24'h00FFFF;
  localparam logic [23:0] AMASK_1MB = 24'h0FFFFF;
  localparam logic [23:0] AMASK_ADV = 24'hFFFFFF;

  // ----------------------------------------------------------------
  // Condition code flag positions
  // ----------------------------------------------------------------
  localparam int FL_IMASK = 7;
  localparam int FL_USER_MASK = 6;
  localparam int FL_H = 5;
  localparam int FL_USER = 4;
  localparam int FL_N = 3;
  localparam int FL_Z = 2;
  localparam int FL_V = 1;
  localparam int FL_C = 0;

  typedef enum logic [1:0] {SZ_B = 2'h0, SZ_W = 2'h1, SZ_L = 2'h2} cpf_size_e;

  typedef enum logic [4:0] {
    OP_NOP, OP_MOV, OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_CMP, OP_NEG,
    OP_AND, OP_OR, OP_XOR, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR,
    OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB, OP_BSET, OP_BCLR, OP_BNOT, OP_BTST,
    OP_BAND, OP_BOR, OP_BXOR, OP_BLD, OP_BST, OP_LOAD_FLAGS,
    OP_STORE_FLAGS, OP_AND_FLAGS, OP_OR_FLAGS, OP_XOR_FLAGS
  } cpf_op_e;

  // ----------------------------------------------------------------
  // Operand access helpers
  // ----------------------------------------------------------------
  // Shift that brings an operand's sign bit up to bit 31
  function automatic logic [5:0] size_shift(cpf_size_e s);
    unique case (s)
      SZ_B: return 6'h18;
      SZ_W: return 6'h10;
      default: return 6'h00;
    endcase
  endfunction

  function automatic logic [31:0] part_get(logic [31:0] w, cpf_size_e s,
                                           logic hi);
    unique case (s)
      SZ_B: return hi ? {24'h000000, w[15:8]} : {24'h000000, w[7:0]}; // RQ3
      SZ_W: return hi ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]}; // RQ2
      default: return w; // RQ1
    endcase
  endfunction

  function automatic logic [31:0] part_put(logic [31:0] w, logic [31:0] v,
                                           cpf_size_e s, logic hi);
    unique case (s)
      SZ_B: return hi ? {w[31:16], v[7:0], w[7:0]} : {w[31:8], v[7:0]}; // RQ23
      SZ_W: return hi ? {v[15:0], w[15:0]} : {w[31:16], v[15:0]}; // RQ23
      default: return v;
    endcase
  endfunction

endpackage

// ==== verilog/cpf_if.sv ====
`timescale 1ns/1ps
interface cpf_alu_if;
  import cpf_pkg::*;
  cpf_op_e op;
  cpf_size_e size;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] res;
  logic [7:0] flags_in;
  logic [7:0] flags_out;
  logic res_we;
  modport core (output op, size, a, b, flags_in,
                input res, flags_out, res_we);
  modport alu (input op, size, a, b, flags_in,
               output res, flags_out, res_we);
endinterface

interface cpf_gpr_if;
  logic we;
  logic [2:0] widx;
  logic [31:0] wdata;
  logic [31:0] q [8];
  modport core (output we, widx, wdata, input q);
  modport bank (input we, widx, wdata, output q);
endinterface

// ==== verilog/cpf_gpr_bank.sv ====
`timescale 1ns/1ps
module cpf_gpr_bank (
  input wire logic clk,
  cpf_gpr_if.bank gb
);
  import cpf_pkg::*;

  // No reset: contents stay undefined until software writes them
  logic [31:0] regs [GPR_COUNT];

  always_ff @(posedge clk)
    if (gb.we)
      regs[gb.widx] <= gb.wdata; // RQ1 RQ17

  assign gb.q = regs;
endmodule // cpf_gpr_bank

// ==== verilog/cpf_alu.sv ====
`timescale 1ns/1ps
module cpf_alu (
  cpf_alu_if.alu ab
);
  import cpf_pkg::*;

  // Operands are worked top-aligned so one adder serves all sizes
  logic [5:0] sh;
  logic [31:0] lsb, low, x, y, ya, ci, r;
  logic [32:0] sum;
  logic [28:0] hsum;
  logic sub, add_adj, lo_fix, hi_fix;
  logic [7:0] dadj, dres;

  assign sh = size_shift(ab.size);
  assign lsb = 32'h00000001 << sh;
  assign low = lsb - 32'h00000001;
  assign sub = ab.op inside {OP_SUB, OP_SUBX, OP_CMP, OP_NEG};
  assign x = (ab.op == OP_NEG) ? 32'h00000000 : ab.a << sh;
  assign y = ((ab.op == OP_NEG) ? ab.a : ab.b) << sh;
  assign ya = sub ? ~y & ~low : y;
  assign ci = (ab.op == OP_ADDX) ? (ab.flags_in[FL_C] ? lsb : 32'h0) :
              (ab.op == OP_SUBX) ? (ab.flags_in[FL_C] ? 32'h0 : lsb) :
              sub ? lsb : 32'h00000000;
  assign sum = {1'b0, x} + {1'b0, ya} + {1'b0, ci};
  assign hsum = {1'b0, x[27:0]} + {1'b0, ya[27:0]} + {1'b0, ci[27:0]};

  // Decimal adjust treats the byte as two packed digits
  assign add_adj = ab.op == OP_DEC_ADJ_ADD;
  assign lo_fix = ab.flags_in[FL_H] | (add_adj & (ab.a[3:0] > 4'h9)); // RQ21
  assign hi_fix = ab.flags_in[FL_C] | (add_adj & (ab.a[7:0] > 8'h99)); // RQ21
  assign dadj = {hi_fix ? 4'h6 : 4'h0, lo_fix ? 4'h6 : 4'h0};
  assign dres = add_adj ? ab.a[7:0] + dadj : ab.a[7:0] - dadj;

  always_comb
  begin
    r = sum[31:0];
    ab.flags_out = ab.flags_in;
    ab.res_we = 1'b1;
    unique case (ab.op)
      OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_CMP, OP_NEG:
      begin
        ab.flags_out[FL_H] = hsum[28] ^ sub; // RQ9
        ab.flags_out[FL_C] = sum[32] ^ sub; // RQ14
        ab.flags_out[FL_V] = (x[31] ^ r[31]) & ~(x[31] ^ y[31] ^ sub); // RQ13
        ab.res_we = ab.op != OP_CMP;
      end
      OP_AND, OP_OR, OP_XOR:
      begin
        r = (ab.op == OP_AND) ? x & y : (ab.op == OP_OR) ? x | y : x ^ y;
        ab.flags_out[FL_V] = 1'b0;
      end
      OP_SHL, OP_ROTL:
      begin
        r = (x << 1) | ((ab.op == OP_ROTL && x[31]) ? lsb : 32'h0);
        ab.flags_out[FL_C] = x[31]; // RQ14
        ab.flags_out[FL_V] = 1'b0;
      end
      OP_SHR, OP_ROTR:
      begin
        r = ((x >> 1) & ~low) |
            ((ab.op == OP_ROTR && |(x & lsb)) ? 32'h80000000 : 32'h0);
        ab.flags_out[FL_C] = |(x & lsb); // RQ14
        ab.flags_out[FL_V] = 1'b0;
      end
      OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB:
      begin
        r = {dres, 24'h000000};
        ab.flags_out[FL_C] = add_adj ? hi_fix : ab.flags_in[FL_C];
      end
      default:
        ab.res_we = 1'b0;
    endcase
    ab.flags_out[FL_N] = r[31]; // RQ11
    ab.flags_out[FL_Z] = r == 32'h00000000; // RQ12
    ab.res = r >> sh;
  end
endmodule // cpf_alu

// ==== verilog/cpf_core_regs.sv ====
// How it works
// RQ1: Eight general registers, 32/16/8-bit access.
// RQ2: Each register splits into extended, base halves.
// RQ3: Base half splits into high, low bytes.
// RQ4: Register seven doubles as stack pointer.
// RQ5: 24-bit program counter, fetch bit zero forced.
// RQ6: Mask bit blocks interrupts except non-maskable.
// RQ7: Exception start sets the mask bit.
// RQ8: User-mask bit software-accessible, extra interrupt mask.
// RQ9: Half-carry from bit 3, 11, 27.
// RQ10: User bit changed only by flag instructions.
// RQ11: Negative flag copies result sign bit.
// RQ12: Zero flag marks zero result.
// RQ13: Overflow flag marks arithmetic overflow.
// RQ14: Carry flag: carry, borrow, shifted-out bit.
// RQ15: Bit ops use carry, address bits 0-7.
// RQ16: Branches test N,Z,V,C; flag instructions.
// RQ17: Reset loads vector, sets mask; rest undefined.
// RQ18: Software sets stack pointer right after reset.
// RQ19: Normal 64-kbyte or advanced 16-Mbyte space.
// RQ20: 1-Mbyte modes ignore upper four address bits.
// RQ21: Decimal adjust uses two packed digits.
// RQ22: Odd wide access address forced even.
// RQ23: Extended half high, base half low, bytes.
`timescale 1ns/1ps
module cpf_core_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire cpf_pkg::cpf_op_e cmd_op,
  input wire cpf_pkg::cpf_size_e cmd_size,
  input wire logic [2:0] cmd_dst_idx,
  input wire logic cmd_dst_hi,
  input wire logic cmd_src_is_reg,
  input wire logic [2:0] cmd_src_idx,
  input wire logic cmd_src_hi,
  input wire logic [31:0] cmd_imm,
  input wire logic [2:0] cmd_bit,
  input wire logic [3:0] branch_cond,
  input wire logic exc_start,
  input wire logic vector_valid,
  input wire logic [23:0] vector_pc,
  input wire logic pc_write,
  input wire logic [23:0] pc_value,
  input wire logic sp_push,
  input wire logic sp_pop,
  input wire logic cpu_advanced,
  input wire logic addr_20bit,
  input wire logic [23:0] eff_addr,
  input wire logic eff_wide,
  input wire logic irq_req,
  input wire logic irq_user_req,
  input wire logic user_mask_en,
  input wire logic nmi_req,
  input wire logic [2:0] rd_idx,
  input wire cpf_pkg::cpf_size_e rd_size,
  input wire logic rd_hi,
  output logic vector_req,
  output logic [23:0] pc_out,
  output logic [23:0] fetch_addr,
  output logic [23:0] bus_addr,
  output logic [7:0] condition_code_flags,
  output logic [31:0] sp_out,
  output logic [31:0] rd_data,
  output logic irq_take,
  output logic branch_take
);
  import cpf_pkg::*;

  typedef enum logic [1:0] {
    ST_VECTOR = 2'h1,
    ST_RUN = 2'h2
  } cpf_state_e;

  cpf_state_e state, next_state;
  logic rst_meta, rst_n;
  logic run, go, byte_op, wr_en, sp_adj_en, bit_val, imask;
  cpf_size_e op_size;
  logic [31:0] dst_word, dst_opnd, src_opnd, src_al, wr_part, cmd_word;
  logic [31:0] sp_word, sp_next;
  logic [7:0] next_flags, bit_mask;
  logic [23:0] next_pc, amask;

  cpf_alu_if alu_bus ();
  cpf_gpr_if gpr_bus ();

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end

  // ----------------------------------------------------------------
  // Operand decode
  // ----------------------------------------------------------------
  assign run = state == ST_RUN;
  assign go = cmd_valid && run;
  assign byte_op = cmd_op inside {[OP_DEC_ADJ_ADD:OP_XOR_FLAGS]};
  assign op_size = byte_op ? SZ_B : cmd_size;
  assign dst_word = gpr_bus.q[cmd_dst_idx];
  assign dst_opnd = part_get(dst_word, op_size, cmd_dst_hi);
  assign src_opnd = cmd_src_is_reg ?
                    part_get(gpr_bus.q[cmd_src_idx], op_size, cmd_src_hi) :
                    part_get(cmd_imm, op_size, 1'b0);
  assign src_al = src_opnd << size_shift(op_size);
  assign bit_val = dst_opnd[cmd_bit]; // RQ15
  assign bit_mask = 8'h01 << cmd_bit; // RQ15
  assign imask = condition_code_flags[FL_IMASK];

  assign alu_bus.op = cmd_op;
  assign alu_bus.size = op_size;
  assign alu_bus.a = dst_opnd;
  assign alu_bus.b = src_opnd;
  assign alu_bus.flags_in = condition_code_flags;

  cpf_alu u_alu (
    .ab(alu_bus.alu)
  );

  // ----------------------------------------------------------------
  // Instruction effects on registers and flags
  // ----------------------------------------------------------------
  always_comb
  begin
    next_flags = condition_code_flags;
    wr_part = alu_bus.res;
    wr_en = 1'b0;
    if (go)
    begin
      unique case (cmd_op)
        OP_MOV:
        begin
          wr_part = src_opnd;
          wr_en = 1'b1;
          next_flags[FL_N] = src_al[31]; // RQ11
          next_flags[FL_Z] = src_opnd == 32'h00000000; // RQ12
          next_flags[FL_V] = 1'b0;
        end
        OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_CMP, OP_NEG, OP_AND, OP_OR,
        OP_XOR, OP_SHL, OP_SHR, OP_ROTL, OP_ROTR, OP_DEC_ADJ_ADD,
        OP_DEC_ADJ_SUB:
        begin
          next_flags = alu_bus.flags_out;
          wr_en = alu_bus.res_we;
        end
        OP_BSET, OP_BCLR, OP_BNOT:
        begin
          wr_en = 1'b1;
          wr_part = {24'h000000,
                     (cmd_op == OP_BSET) ? dst_opnd[7:0] | bit_mask :
                     (cmd_op == OP_BCLR) ? dst_opnd[7:0] & ~bit_mask :
                     dst_opnd[7:0] ^ bit_mask};
        end
        OP_BTST:
          next_flags[FL_Z] = ~bit_val;
        OP_BAND:
          next_flags[FL_C] = condition_code_flags[FL_C] & bit_val; // RQ15
        OP_BOR:
          next_flags[FL_C] = condition_code_flags[FL_C] | bit_val; // RQ15
        OP_BXOR:
          next_flags[FL_C] = condition_code_flags[FL_C] ^ bit_val; // RQ15
        OP_BLD:
          next_flags[FL_C] = bit_val; // RQ15
        OP_BST:
        begin
          wr_en = 1'b1;
          wr_part = {24'h000000, condition_code_flags[FL_C] ?
                     dst_opnd[7:0] | bit_mask : dst_opnd[7:0] & ~bit_mask};
        end
        // User bits change only through this group
        OP_LOAD_FLAGS:
          next_flags = src_opnd[7:0]; // RQ8 RQ10 RQ16
        OP_STORE_FLAGS:
        begin
          wr_en = 1'b1;
          wr_part = {24'h000000, condition_code_flags}; // RQ16
        end
        OP_AND_FLAGS:
          next_flags = condition_code_flags & src_opnd[7:0]; // RQ16
        OP_OR_FLAGS:
          next_flags = condition_code_flags | src_opnd[7:0]; // RQ16
        OP_XOR_FLAGS:
          next_flags = condition_code_flags ^ src_opnd[7:0]; // RQ16
        default:
          next_flags = condition_code_flags;
      endcase
    end
    // Exception entry wins over a same-cycle flag write
    if (exc_start && run)
      next_flags[FL_IMASK] = 1'b1; // RQ7
  end

  // ----------------------------------------------------------------
  // Register bank and stack pointer
  // ----------------------------------------------------------------
  assign cmd_word = part_put(dst_word, wr_part, op_size, cmd_dst_hi);
  assign sp_word = gpr_bus.q[SP_INDEX];
  assign sp_next = sp_push ? sp_word - SP_STEP : sp_word + SP_STEP; // RQ4
  // An explicit write to the stack register beats an implicit step
  assign sp_adj_en = run && (sp_push ^ sp_pop) &&
                     !(wr_en && cmd_dst_idx == SP_INDEX); // RQ4
  assign gpr_bus.we = wr_en || sp_adj_en;
  assign gpr_bus.widx = wr_en ? cmd_dst_idx : SP_INDEX;
  assign gpr_bus.wdata = wr_en ? cmd_word : sp_next;

  cpf_gpr_bank u_bank (
    .clk(clk),
    .gb(gpr_bus.bank)
  );

  // ----------------------------------------------------------------
  // Sequencing, program counter, addressing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_VECTOR:
        if (vector_valid)
          next_state = ST_RUN;
      ST_RUN:
        if (exc_start)
          next_state = ST_VECTOR;
      default:
        next_state = ST_VECTOR;
    endcase
  end

  assign next_pc = (state == ST_VECTOR && vector_valid) ? vector_pc : // RQ17
                   (run && pc_write && !exc_start) ? pc_value : pc_out;
  assign amask = !cpu_advanced ? AMASK_NORMAL : // RQ19
                 addr_20bit ? AMASK_1MB : AMASK_ADV; // RQ20

  function automatic logic cond_met(logic [3:0] c, logic [7:0] f);
    logic r;
    unique case (c[3:1])
      3'h0: r = 1'b1;
      3'h1: r = ~(f[FL_C] | f[FL_Z]);
      3'h2: r = ~f[FL_C];
      3'h3: r = ~f[FL_Z];
      3'h4: r = ~f[FL_V];
      3'h5: r = ~f[FL_N];
      3'h6: r = ~(f[FL_N] ^ f[FL_V]);
      default: r = ~(f[FL_Z] | (f[FL_N] ^ f[FL_V]));
    endcase
    return r ^ c[0];
  endfunction

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      state <= ST_VECTOR;
      pc_out <= PC_RESET;
      condition_code_flags <= FLAGS_RESET; // RQ17
      vector_req <= 1'b1;
      fetch_addr <= PC_RESET;
      bus_addr <= PC_RESET;
      sp_out <= 32'h00000000;
      rd_data <= 32'h00000000;
      irq_take <= 1'b0;
      branch_take <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pc_out <= next_pc;
      condition_code_flags <= next_flags;
      vector_req <= next_state == ST_VECTOR;
      fetch_addr <= {next_pc[23:1] & amask[23:1], 1'b0}; // RQ5
      bus_addr <= eff_addr & amask & {23'h7FFFFF, ~eff_wide}; // RQ22
      sp_out <= sp_word;
      rd_data <= part_get(gpr_bus.q[rd_idx], rd_size, rd_hi);
      irq_take <= run && (nmi_req || (irq_req && !imask) || // RQ6
                  (irq_user_req && !imask && // RQ8
                   !(user_mask_en && condition_code_flags[FL_USER_MASK])));
      branch_take <= cond_met(branch_cond, condition_code_flags); // RQ16
    end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_VECTOR_MASK: assert property ( // RQ7
    @(posedge clk) disable iff (!rst_n)
    state == ST_VECTOR |-> condition_code_flags[FL_IMASK])
    else $error("mask bit clear during vector fetch");

  AST_VECTOR_LOAD: assert property ( // RQ17
    @(posedge clk) disable iff (!rst_n)
    state == ST_VECTOR && vector_valid
    |=> pc_out == $past(vector_pc) && state == ST_RUN)
    else $error("vector not loaded into program counter");

  AST_NMI_TAKEN: assert property ( // RQ6
    @(posedge clk) disable iff (!rst_n)
    run && nmi_req |=> irq_take)
    else $error("non-maskable interrupt not taken");

  AST_IRQ_MASKED: assert property ( // RQ6
    @(posedge clk) disable iff (!rst_n)
    run && imask && !nmi_req |=> !irq_take)
    else $error("interrupt taken while masked");

  AST_FETCH_EVEN: assert property ( // RQ5
    @(posedge clk) disable iff (!rst_n)
    run && pc_write && !exc_start && cpu_advanced && !addr_20bit
    |=> fetch_addr == {$past(pc_value[23:1]), 1'b0})
    else $error("fetch address wrong");

  AST_NORMAL_SPACE: assert property ( // RQ19
    @(posedge clk) disable iff (!rst_n)
    !cpu_advanced |=> bus_addr[23:16] == 8'h00)
    else $error("normal mode address beyond 64 kbyte");

  AST_ADDR_20BIT: assert property ( // RQ20
    @(posedge clk) disable iff (!rst_n)
    cpu_advanced && addr_20bit
    |=> bus_addr == {4'h0, $past(eff_addr[19:1]), 1'b0} || !$past(eff_wide))
    else $error("20-bit address not truncated");

  AST_WIDE_EVEN: assert property ( // RQ22
    @(posedge clk) disable iff (!rst_n)
    eff_wide |=> !bus_addr[0])
    else $error("wide access at odd address");

  AST_MOV_ZERO: assert property ( // RQ12
    @(posedge clk) disable iff (!rst_n)
    go && cmd_op == OP_MOV && src_opnd == 32'h00000000
    |=> condition_code_flags[FL_Z] && !condition_code_flags[FL_V])
    else $error("zero flag not set on zero move");

  AST_HALF_CARRY: assert property ( // RQ9
    @(posedge clk) disable iff (!rst_n)
    go && cmd_op == OP_ADD && op_size == SZ_B &&
    ({1'b0, dst_opnd[3:0]} + {1'b0, src_opnd[3:0]}) > 5'h0F
    |=> condition_code_flags[FL_H])
    else $error("half carry missing on byte add");

  AST_USER_BIT: assert property ( // RQ10
    @(posedge clk) disable iff (!rst_n)
    !(go && cmd_op inside {OP_LOAD_FLAGS, OP_AND_FLAGS, OP_OR_FLAGS,
                           OP_XOR_FLAGS})
    |=> $stable(condition_code_flags[FL_USER]))
    else $error("user bit changed by other instruction");

  AST_SP_PUSH: assert property ( // RQ4
    @(posedge clk) disable iff (!rst_n)
    run && sp_push && !sp_pop && !(wr_en && cmd_dst_idx == SP_INDEX)
    |-> ##2 sp_out == $past(sp_word, 2) - SP_STEP)
    else $error("stack pointer not decremented");

endmodule // cpf_core_regs

// ==== dv/cpu_register_file_and_flags_bench.sv ====
`timescale 1ns/1ps
module cpu_register_file_and_flags_bench;
  import cpf_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic cmd_valid = 1'h0, cmd_dst_hi = 1'h0, rd_hi = 1'h0;
  cpf_op_e cmd_op = OP_NOP;
  cpf_size_e cmd_size = SZ_B, rd_size = SZ_L;
  logic [2:0] cmd_dst_idx = 3'h0, cmd_bit = 3'h0, rd_idx = 3'h0;
  logic [31:0] cmd_imm = 32'h00000000;
  logic [3:0] branch_cond = 4'h0;
  logic exc_start = 1'h0, vector_valid = 1'h0, sp_push = 1'h0;
  logic sp_pop = 1'h0, cpu_advanced = 1'h1, addr_20bit = 1'h0;
  logic eff_wide = 1'h0, irq_req = 1'h0, irq_user_req = 1'h0;
  logic user_mask_en = 1'h0, nmi_req = 1'h0, pc_write = 1'h0;
  logic [23:0] vector_pc = 24'h000000, eff_addr = 24'h000000;
  logic [23:0] pc_value = 24'h000000;
  logic vector_req, irq_take, branch_take;
  logic [23:0] pc_out, fetch_addr, bus_addr;
  logic [7:0] ccf;
  logic [31:0] sp_out, rd_data;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;

  cpf_core_regs dut (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_size(cmd_size), .cmd_dst_idx(cmd_dst_idx),
    .cmd_dst_hi(cmd_dst_hi), .cmd_src_is_reg(1'h0), .cmd_src_idx(3'h0),
    .cmd_src_hi(1'h0), .cmd_imm(cmd_imm), .cmd_bit(cmd_bit),
    .branch_cond(branch_cond), .exc_start(exc_start),
    .vector_valid(vector_valid), .vector_pc(vector_pc), .pc_write(pc_write),
    .pc_value(pc_value), .sp_push(sp_push), .sp_pop(sp_pop),
    .cpu_advanced(cpu_advanced), .addr_20bit(addr_20bit),
    .eff_addr(eff_addr), .eff_wide(eff_wide), .irq_req(irq_req),
    .irq_user_req(irq_user_req), .user_mask_en(user_mask_en),
    .nmi_req(nmi_req), .rd_idx(rd_idx), .rd_size(rd_size), .rd_hi(rd_hi),
    .vector_req(vector_req), .pc_out(pc_out), .fetch_addr(fetch_addr),
    .bus_addr(bus_addr), .condition_code_flags(ccf), .sp_out(sp_out),
    .rd_data(rd_data), .irq_take(irq_take), .branch_take(branch_take)
  );

  always #2.5 clk = ~clk;

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Leaves cmd_valid high so commands can run back to back
  task automatic run(input cpf_op_e op, input cpf_size_e sz,
                     input logic [2:0] d, input logic h,
                     input logic [31:0] v);
    cmd_valid = 1'h1;
    cmd_op = op;
    cmd_size = sz;
    cmd_dst_idx = d;
    cmd_dst_hi = h;
    cmd_imm = v;
    @(negedge clk);
  endtask

  task automatic idle();
    cmd_valid = 1'h0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [2:0] i, input cpf_size_e s,
                    input logic h, input logic [31:0] exp);
    rd_idx = i;
    rd_size = s;
    rd_hi = h;
    @(negedge clk);
    chk("rd_data", exp, rd_data);
  endtask

  task automatic load_vector(input logic [23:0] v);
    vector_valid = 1'h1;
    vector_pc = v;
    @(negedge clk);
    vector_valid = 1'h0;
    chk("vector_req", 32'h0, vector_req);
    chk("pc_out", v, pc_out);
    chk("fetch_addr", {v[23:1], 1'h0}, fetch_addr);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (6) @(negedge clk);
    chk("flags", 32'h80, ccf);
    chk("vector_req", 32'h1, vector_req);
    resetn = 1'h1;
    repeat (3) @(negedge clk);
    load_vector(24'h012345);
    $display("reset test done");
  endtask

  task automatic t_parts();
    run(OP_MOV, SZ_L, 3'h0, 1'h0, 32'h11223344);
    run(OP_MOV, SZ_W, 3'h0, 1'h1, 32'h0000AABB);
    run(OP_MOV, SZ_B, 3'h0, 1'h1, 32'h00000055);
    run(OP_MOV, SZ_B, 3'h0, 1'h0, 32'h00000066);
    run(OP_MOV, SZ_L, 3'h3, 1'h0, 32'hCAFE0001);
    idle();
    rd(3'h0, SZ_L, 1'h0, 32'hAABB5566);
    rd(3'h0, SZ_W, 1'h1, 32'h0000AABB);
    rd(3'h0, SZ_W, 1'h0, 32'h00005566);
    rd(3'h0, SZ_B, 1'h1, 32'h00000055);
    rd(3'h0, SZ_B, 1'h0, 32'h00000066);
    rd(3'h3, SZ_L, 1'h0, 32'hCAFE0001);
    $display("register parts test done");
  endtask

  task automatic t_arith();
    cpf_op_e op [8] = '{OP_ADD, OP_ADD, OP_ADD, OP_ADD, OP_ADD, OP_ADD,
                        OP_SUB, OP_SUB};
    cpf_size_e sz [8] = '{SZ_B, SZ_B, SZ_W, SZ_L, SZ_B, SZ_B, SZ_B, SZ_B};
    logic [31:0] a [8] = '{32'h0F, 32'hFF, 32'h0800, 32'h08000000, 32'h7F,
                           32'h10, 32'h00, 32'h0E};
    logic [31:0] b [8] = '{32'h01, 32'h01, 32'h0800, 32'h08000000, 32'h01,
                           32'h01, 32'h01, 32'h01};
    logic [7:0] f [8] = '{8'hA0, 8'hA5, 8'hA0, 8'hA0, 8'hAA, 8'h80,
                          8'hA9, 8'h80};
    for (int i = 0; i < 8; i++)
    begin
      run(OP_MOV, sz[i], 3'h1, 1'h0, a[i]);
      run(op[i], sz[i], 3'h1, 1'h0, b[i]);
      idle();
      chk("flags", f[i], ccf);
    end
    branch_cond = 4'h0;
    @(negedge clk);
    chk("branch_take", 32'h1, branch_take);
    branch_cond = 4'h1;
    @(negedge clk);
    chk("branch_take", 32'h0, branch_take);
    branch_cond = 4'h8;
    @(negedge clk);
    chk("branch_take", 32'h1, branch_take);
    $display("arithmetic flags test done");
  endtask

  task automatic t_flag_ops();
    run(OP_LOAD_FLAGS, SZ_B, 3'h0, 1'h0, 32'h50);
    chk("flags", 32'h50, ccf);
    run(OP_AND_FLAGS, SZ_B, 3'h0, 1'h0, 32'hEF);
    chk("flags", 32'h40, ccf);
    run(OP_OR_FLAGS, SZ_B, 3'h0, 1'h0, 32'h01);
    chk("flags", 32'h41, ccf);
    run(OP_STORE_FLAGS, SZ_B, 3'h2, 1'h0, 32'h00);
    run(OP_XOR_FLAGS, SZ_B, 3'h0, 1'h0, 32'h41);
    chk("flags", 32'h00, ccf);
    idle();
    rd(3'h2, SZ_B, 1'h0, 32'h41);
    $display("flag instruction test done");
  endtask

  task automatic t_irq();
    irq_req = 1'h1;
    @(negedge clk);
    chk("irq_take", 32'h1, irq_take);
    run(OP_LOAD_FLAGS, SZ_B, 3'h0, 1'h0, 32'h80);
    idle();
    chk("irq_take", 32'h0, irq_take);
    nmi_req = 1'h1;
    @(negedge clk);
    chk("irq_take", 32'h1, irq_take);
    nmi_req = 1'h0;
    irq_req = 1'h0;
    run(OP_LOAD_FLAGS, SZ_B, 3'h0, 1'h0, 32'h40);
    cmd_valid = 1'h0;
    irq_user_req = 1'h1;
    user_mask_en = 1'h1;
    @(negedge clk);
    @(negedge clk);
    chk("irq_take", 32'h0, irq_take);
    user_mask_en = 1'h0;
    @(negedge clk);
    chk("irq_take", 32'h1, irq_take);
    irq_user_req = 1'h0;
    $display("interrupt mask test done");
  endtask

  task automatic t_exception();
    exc_start = 1'h1;
    @(negedge clk);
    exc_start = 1'h0;
    chk("vector_req", 32'h1, vector_req);
    chk("flags", 32'hC0, ccf);
    run(OP_LOAD_FLAGS, SZ_B, 3'h0, 1'h0, 32'h00);
    idle();
    chk("flags", 32'hC0, ccf);
    load_vector(24'hABCDEF);
    $display("exception test done");
  endtask

  task automatic t_stack();
    run(OP_MOV, SZ_L, 3'h7, 1'h0, 32'h00001000);
    cmd_valid = 1'h0;
    sp_push = 1'h1;
    @(negedge clk);
    sp_push = 1'h0;
    @(negedge clk);
    chk("sp_out", 32'h00000FFC, sp_out);
    sp_pop = 1'h1;
    @(negedge clk);
    @(negedge clk);
    chk("sp_out", 32'h00001000, sp_out);
    @(negedge clk);
    chk("sp_out", 32'h00001004, sp_out);
    sp_pop = 1'h0;
    rd(3'h7, SZ_L, 1'h0, 32'h00001008);
    $display("stack test done");
  endtask

  task automatic t_addr();
    logic [2:0] m [4] = '{3'h1, 3'h7, 3'h5, 3'h4};
    logic [23:0] e [4] = '{24'h003456, 24'h023456, 24'h123456, 24'h123457};
    eff_addr = 24'h123457;
    for (int i = 0; i < 4; i++)
    begin
      {cpu_advanced, addr_20bit, eff_wide} = m[i];
      @(negedge clk);
      chk("bus_addr", e[i], bus_addr);
    end
    pc_write = 1'h1;
    pc_value = 24'h00ABC1;
    @(negedge clk);
    pc_write = 1'h0;
    chk("pc_out", 32'h00ABC1, pc_out);
    chk("fetch_addr", 32'h00ABC0, fetch_addr);
    $display("address test done");
  endtask

  task automatic t_bits();
    cmd_bit = 3'h7;
    run(OP_MOV, SZ_B, 3'h4, 1'h0, 32'h38);
    run(OP_ADD, SZ_B, 3'h4, 1'h0, 32'h25);
    run(OP_DEC_ADJ_ADD, SZ_B, 3'h4, 1'h0, 32'h0);
    run(OP_BSET, SZ_B, 3'h4, 1'h0, 32'h0);
    run(OP_BLD, SZ_B, 3'h4, 1'h0, 32'h0);
    idle();
    chk("flags", 32'hC1, ccf);
    rd(3'h4, SZ_B, 1'h0, 32'hE3);
    $display("bit and decimal test done");
  endtask

  initial
  begin
    t_reset();
    t_parts();
    t_arith();
    t_flag_ops();
    t_irq();
    t_exception();
    t_stack();
    t_addr();
    t_bits();
    stop_test();
  end
endmodule // cpu_register_file_and_flags_bench
